// ### hw/branch_cond_to_link_reg.sv
`timescale 1ns/10ps

module branch_cond_to_link_reg
    import branch_lr_pkg::*;
#(
    parameter int XLEN = 32
) (
    input wire logic CLK_SYS_IN,
    input wire logic RESET_IN,
    input wire logic INSTR_VALID_IN,
    input wire logic [31:0] INSTR_IN,
    input wire logic [XLEN-1:0] INSTR_ADDR_IN,
    input wire logic [XLEN-1:0] LINK_REG_IN,
    input wire logic [XLEN-1:0] COUNT_REG_IN,
    input wire logic [31:0] COND_REG_IN,
    input wire logic [1:0] ENCODING_MODE_IN,
    output logic DONE_OUT,
    output logic TAKEN_OUT,
    output logic [XLEN-1:0] TARGET_OUT,
    output logic INVALID_OUT,
    output logic LINK_WE_OUT,
    output logic [XLEN-1:0] LINK_DATA_OUT,
    output logic COUNT_WE_OUT,
    output logic [XLEN-1:0] COUNT_DATA_OUT,
    output logic FIXED_EXC_WE_OUT,
    output logic CR0_WE_OUT,
    output pred_hint_t PRED_HINT_OUT,
    output usage_hint_t USAGE_HINT_OUT
);

    generate
        if (XLEN != 32) begin : g_bad_xlen
            $error("branch_cond_to_link_reg supports XLEN of 32 only");
        end
    endgenerate

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    logic is_ours;
    logic [4:0] branch_option_field;
    logic [4:0] condition_bit_index;
    logic [1:0] branch_usage_hint;
    logic link_enable_bit;
    logic cond_bit;
    logic [XLEN-1:0] count_dec;
    logic count_zero;
    logic z_bad;
    logic invalid_form;
    logic cond_ok;
    logic count_ok;
    logic take;
    pred_hint_t pred_hint;

    always_comb begin
        is_ours = INSTR_VALID_IN
            && (INSTR_IN[OPCODE_HI:OPCODE_LO] == PRIMARY_OPCODE)
            && (INSTR_IN[XOP_HI:XOP_LO] == EXTENDED_OPCODE);
        branch_option_field = INSTR_IN[OPTION_HI:OPTION_LO];
        condition_bit_index = INSTR_IN[CBIT_HI:CBIT_LO];
        branch_usage_hint = INSTR_IN[USAGE_HI:USAGE_LO];
        link_enable_bit = INSTR_IN[LINK_POS];
        cond_bit = COND_REG_IN[COND_MSB_INDEX - condition_bit_index];
    end

    count_step #(
        .WIDTH(XLEN)
    ) u_count_step (
        .count_in(COUNT_REG_IN),
        .dec_out(count_dec),
        .zero_out(count_zero)
    );

    // ------------------------------------------------------------
    // Form check and branch decision
    // ------------------------------------------------------------
    // Option bit 4 skips the condition, bit 2 skips the count; hint
    // positions are never read here, so hints cannot sway the outcome.
    always_comb begin
        if (branch_option_field[4] && branch_option_field[2]) begin
            z_bad = branch_option_field[3] | branch_option_field[1]
                | branch_option_field[0];
        end else if (ENCODING_MODE_IN == MODE_ORIGINAL) begin
            if (branch_option_field[4]) begin
                z_bad = branch_option_field[3];
            end else if (branch_option_field[2]) begin
                z_bad = branch_option_field[1];
            end else begin
                z_bad = 1'b0;
            end
        end else begin
            // Revised: of the forms left after branch-always, only count-and-condition carries z
            z_bad = !branch_option_field[4] && !branch_option_field[2]
                && branch_option_field[0];
        end
        invalid_form = is_ours && (ENCODING_MODE_IN != MODE_LEGACY) && z_bad;
        cond_ok = branch_option_field[4]
            || (cond_bit == branch_option_field[3]);
        count_ok = branch_option_field[2]
            || (!count_zero ^ branch_option_field[1]);
        take = cond_ok && count_ok;
    end

    // ------------------------------------------------------------
    // Prediction hint
    // ------------------------------------------------------------
    always_comb begin
        pred_hint = PRED_NONE;
        if (ENCODING_MODE_IN == MODE_ORIGINAL) begin
            if (!(branch_option_field[4] && branch_option_field[2])
                && branch_option_field[0]) begin
                pred_hint = PRED_TAKEN;
            end
        end else if (ENCODING_MODE_IN != MODE_LEGACY) begin
            if (!branch_option_field[4] && branch_option_field[2]) begin
                pred_hint = pred_hint_t'(branch_option_field[1:0]);
            end else if (branch_option_field[4] && !branch_option_field[2]) begin
                pred_hint = pred_hint_t'({branch_option_field[3],
                    branch_option_field[0]});
            end
        end
    end

    // ------------------------------------------------------------
    // Result registers
    // ------------------------------------------------------------
    logic next_done;
    logic next_taken;
    logic [XLEN-1:0] next_target;
    logic next_invalid;
    logic next_link_we;
    logic [XLEN-1:0] next_link_data;
    logic next_count_we;
    logic [XLEN-1:0] next_count_data;
    pred_hint_t next_pred;
    usage_hint_t next_usage;

    always_comb begin
        next_done = is_ours;
        next_invalid = invalid_form;
        next_taken = is_ours && !invalid_form && take;
        next_target = {LINK_REG_IN[XLEN-1:2], WORD_ALIGN};
        next_link_we = is_ours && !invalid_form && link_enable_bit;
        next_link_data = INSTR_ADDR_IN + XLEN'(INSTR_STEP);
        next_count_we = is_ours && !invalid_form && !branch_option_field[2];
        next_count_data = count_dec;
        next_pred = is_ours ? pred_hint : PRED_NONE;
        next_usage = usage_hint_t'(branch_usage_hint);
    end

    always_ff @(posedge CLK_SYS_IN or posedge RESET_IN) begin
        if (RESET_IN) begin
            DONE_OUT <= 1'b0;
            TAKEN_OUT <= 1'b0;
            TARGET_OUT <= '0;
            INVALID_OUT <= 1'b0;
            LINK_WE_OUT <= 1'b0;
            LINK_DATA_OUT <= '0;
            COUNT_WE_OUT <= 1'b0;
            COUNT_DATA_OUT <= '0;
            FIXED_EXC_WE_OUT <= 1'b0;
            CR0_WE_OUT <= 1'b0;
            PRED_HINT_OUT <= PRED_NONE;
            USAGE_HINT_OUT <= USAGE_SAME_TARGET;
        end else begin
            DONE_OUT <= next_done;
            TAKEN_OUT <= next_taken;
            TARGET_OUT <= next_target;
            INVALID_OUT <= next_invalid;
            LINK_WE_OUT <= next_link_we;
            LINK_DATA_OUT <= next_link_data;
            COUNT_WE_OUT <= next_count_we;
            COUNT_DATA_OUT <= next_count_data;
            // Kept as flops so the core sees a defined, never-set strobe
            FIXED_EXC_WE_OUT <= 1'b0;
            CR0_WE_OUT <= 1'b0;
            PRED_HINT_OUT <= next_pred;
            USAGE_HINT_OUT <= next_usage;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (RESET_IN);

    target_form_a: assert property (is_ours |=> TARGET_OUT[1:0] == 2'h0
        && TARGET_OUT[XLEN-1:2] == $past(LINK_REG_IN[XLEN-1:2]))
        else $error("branch target not formed from link register");
    link_write_a: assert property (is_ours && !invalid_form && link_enable_bit
        |=> LINK_WE_OUT && LINK_DATA_OUT == $past(INSTR_ADDR_IN) + XLEN'(INSTR_STEP))
        else $error("link register not given next address");
    no_side_a: assert property (!FIXED_EXC_WE_OUT && !CR0_WE_OUT)
        else $error("exception or condition field written");
    cond_count_a: assert property (is_ours && !invalid_form
        && !branch_option_field[4] && !branch_option_field[2]
        |=> COUNT_WE_OUT && COUNT_DATA_OUT == $past(COUNT_REG_IN) - 1
        && TAKEN_OUT == ($past(cond_bit) == $past(branch_option_field[3])
        && (($past(COUNT_REG_IN) != 1) ^ $past(branch_option_field[1]))))
        else $error("count-and-condition branch wrong");
    count_hold_a: assert property (is_ours && branch_option_field[2]
        && !branch_option_field[4]
        |=> !COUNT_WE_OUT && (INVALID_OUT || TAKEN_OUT ==
        ($past(cond_bit) == $past(branch_option_field[3]))))
        else $error("condition-only branch wrong");
    always_take_a: assert property (is_ours && !invalid_form
        && branch_option_field[4] && branch_option_field[2]
        |=> TAKEN_OUT && !COUNT_WE_OUT)
        else $error("branch-always not taken");
    zbit_inval_a: assert property (is_ours && ENCODING_MODE_IN != MODE_LEGACY
        && branch_option_field == 5'h15
        |=> INVALID_OUT && !TAKEN_OUT && !LINK_WE_OUT && !COUNT_WE_OUT)
        else $error("nonzero z bit accepted");
    legacy_ok_a: assert property (is_ours && ENCODING_MODE_IN == MODE_LEGACY
        |=> DONE_OUT && !INVALID_OUT)
        else $error("legacy form refused");
    orig_hint_a: assert property (is_ours && ENCODING_MODE_IN == MODE_ORIGINAL
        && !branch_option_field[4] && branch_option_field[0]
        |=> PRED_HINT_OUT == PRED_TAKEN)
        else $error("likely-taken hint lost");
    rev_hint_a: assert property (is_ours && ENCODING_MODE_IN == MODE_REVISED
        && !branch_option_field[4] && branch_option_field[2]
        |=> PRED_HINT_OUT == pred_hint_t'($past(branch_option_field[1:0])))
        else $error("revised hint decoded wrong");
    usage_hint_a: assert property (is_ours
        |=> USAGE_HINT_OUT == usage_hint_t'($past(INSTR_IN[12:11])))
        else $error("usage hint decoded wrong");

    link_taken_c: cover property (is_ours && link_enable_bit ##1 TAKEN_OUT);
    count_zero_c: cover property (is_ours && count_zero
        && !branch_option_field[2] ##1 TAKEN_OUT);
    invalid_c: cover property (invalid_form ##1 INVALID_OUT);

endmodule

// ### hw/branch_lr_pkg.sv
package branch_lr_pkg;

    // ------------------------------------------------------------
    // Instruction identity
    // ------------------------------------------------------------
    localparam logic [5:0] PRIMARY_OPCODE = 6'h13;
    localparam logic [9:0] EXTENDED_OPCODE = 10'h010;

    // ------------------------------------------------------------
    // Field positions (little-endian index of a 32-bit word)
    // ------------------------------------------------------------
    localparam int OPCODE_HI = 31;
    localparam int OPCODE_LO = 26;
    localparam int OPTION_HI = 25;
    localparam int OPTION_LO = 21;
    localparam int CBIT_HI = 20;
    localparam int CBIT_LO = 16;
    localparam int USAGE_HI = 12;
    localparam int USAGE_LO = 11;
    localparam int XOP_HI = 10;
    localparam int XOP_LO = 1;
    localparam int LINK_POS = 0;

    // Condition bit 0 is the most significant bit of the register
    localparam logic [4:0] COND_MSB_INDEX = 5'h1F;

    // ------------------------------------------------------------
    // Sequencing and target alignment
    // ------------------------------------------------------------
    localparam int INSTR_STEP = 4;
    localparam logic [1:0] WORD_ALIGN = 2'h0;

    // ------------------------------------------------------------
    // Encoding variants
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_LEGACY = 2'h0;
    localparam logic [1:0] MODE_ORIGINAL = 2'h1;
    localparam logic [1:0] MODE_REVISED = 2'h2;

    // ------------------------------------------------------------
    // Hint codes; order matches the two hint bits directly
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PRED_NONE,
        PRED_RESERVED,
        PRED_NOT_TAKEN,
        PRED_TAKEN
    } pred_hint_t;

    typedef enum logic [1:0] {
        USAGE_SAME_TARGET,
        USAGE_RESERVED_A,
        USAGE_RESERVED_B,
        USAGE_UNPREDICTABLE
    } usage_hint_t;

endpackage

// ### hw/count_step.sv
`timescale 1ns/10ps

module count_step #(
    parameter int WIDTH = 32
) (
    input wire logic [WIDTH-1:0] count_in,
    output logic [WIDTH-1:0] dec_out,
    output logic zero_out
);

    generate
        if (WIDTH < 2) begin : g_bad_width
            $error("count_step needs WIDTH of at least 2");
        end
    endgenerate

    always_comb begin
        dec_out = count_in - {{(WIDTH-1){1'b0}}, 1'b1};
        zero_out = (dec_out == '0);
    end

endmodule

// ### sim/tb_branch_cond_to_link_reg.sv
`timescale 1ns/10ps

module tb_branch_cond_to_link_reg
    import branch_lr_pkg::*;
;
    // ------------------------------------------------------------
    // Expected-result notes
    // ------------------------------------------------------------
    typedef struct {
        logic done, taken, inval, lwe, cwe;
        logic [31:0] tgt, ldata, cdata;
        logic [1:0] pred, usage;
    } note_t;

    logic clk_sys = 1'h0;
    logic reset = 1'h1;
    logic valid = 1'h0;
    logic [31:0] instr = 32'h0, addr = 32'h0, link = 32'h0, count = 32'h0, cond = 32'h0;
    logic [1:0] mode = 2'h0;
    logic done, taken, invalid, link_we, count_we, fixed_we, cr0_we;
    logic [31:0] target, link_data, count_data;
    pred_hint_t pred;
    usage_hint_t usage;
    int n_fail = 0;
    int num_checks = 0;
    int cycles = 0;
    note_t q[$];

    always #4 clk_sys = ~clk_sys;

    branch_cond_to_link_reg #(.XLEN(32)) i_branch_cond_to_link_reg (
        .CLK_SYS_IN(clk_sys), .RESET_IN(reset), .INSTR_VALID_IN(valid), .INSTR_IN(instr),
        .INSTR_ADDR_IN(addr), .LINK_REG_IN(link), .COUNT_REG_IN(count), .COND_REG_IN(cond),
        .ENCODING_MODE_IN(mode), .DONE_OUT(done), .TAKEN_OUT(taken), .TARGET_OUT(target),
        .INVALID_OUT(invalid), .LINK_WE_OUT(link_we), .LINK_DATA_OUT(link_data),
        .COUNT_WE_OUT(count_we), .COUNT_DATA_OUT(count_data), .FIXED_EXC_WE_OUT(fixed_we),
        .CR0_WE_OUT(cr0_we), .PRED_HINT_OUT(pred), .USAGE_HINT_OUT(usage)
    );

    // ------------------------------------------------------------
    // Reference behaviour, worked out independently of the design
    // ------------------------------------------------------------
    function automatic note_t model(logic v, logic [31:0] w, logic [1:0] m,
                                    logic [31:0] a, logic [31:0] l, logic [31:0] c,
                                    logic [31:0] cr);
        note_t n;
        logic [4:0] o;
        logic cb, z;
        logic [31:0] d;
        n = '{default: 0};
        o = w[25:21];
        cb = cr[31 - w[20:16]];
        d = c - 32'h1;
        n.tgt = {l[31:2], 2'h0};
        n.ldata = a + 32'h4;
        n.cdata = d;
        n.usage = w[12:11];
        if (!(v && w[31:26] == PRIMARY_OPCODE && w[10:1] == EXTENDED_OPCODE)) begin
            return n;
        end
        n.done = 1'h1;
        z = 1'h0;
        if (m != MODE_LEGACY) begin
            if (o[4] && o[2]) begin
                z = o[3] | o[1] | o[0];
            end else if (m == MODE_ORIGINAL) begin
                z = o[4] ? o[3] : (o[2] ? o[1] : 1'h0);
            end else begin
                z = (!o[4] && !o[2]) ? o[0] : 1'h0;
            end
        end
        n.inval = z;
        if (z) begin
            return n;
        end
        // Hints never enter the outcome
        n.taken = (o[4] || cb == o[3]) && (o[2] || ((d != 32'h0) != o[1]));
        n.cwe = !o[2];
        n.lwe = w[0];
        if (m == MODE_ORIGINAL) begin
            n.pred = (!(o[4] && o[2]) && o[0]) ? 2'h3 : 2'h0;
        end else if (m != MODE_LEGACY) begin
            n.pred = (o[4] != o[2]) ? {(o[4] ? o[3] : o[1]), o[0]} : 2'h0;
        end
        return n;
    endfunction

    function automatic logic [31:0] mk(logic [4:0] o, logic [4:0] bi, logic [1:0] bh,
                                       logic lk, logic [2:0] junk);
        return {PRIMARY_OPCODE, o, bi, junk, bh, EXTENDED_OPCODE, lk};
    endfunction

    task automatic drive(logic v, logic [31:0] w, logic [1:0] m, logic [31:0] a,
                         logic [31:0] l, logic [31:0] c, logic [31:0] cr);
        @(negedge clk_sys);
        valid = v;
        instr = w;
        mode = m;
        addr = a;
        link = l;
        count = c;
        cond = cr;
        q.push_back(model(v, w, m, a, l, c, cr));
    endtask

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test;
        if (n_fail == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Watcher: one note per driven cycle, answer one cycle later
    // ------------------------------------------------------------
    always @(posedge clk_sys) begin
        note_t n;
        #2;
        check("fixed_exc_we", fixed_we, 32'h0);
        check("cr0_we", cr0_we, 32'h0);
        if (q.size() > 0) begin
            n = q.pop_front();
            check("done", done, n.done);
            check("invalid", invalid, n.inval);
            check("taken", taken, n.taken);
            check("count_we", count_we, n.cwe);
            check("link_we", link_we, n.lwe);
            if (n.taken) check("target", target, n.tgt);
            if (n.lwe) check("link_data", link_data, n.ldata);
            if (n.cwe) check("count_data", count_data, n.cdata);
            if (n.done) check("usage_hint", usage, n.usage);
            if (n.done && !n.inval) check("pred_hint", pred, n.pred);
        end
    end

    // Whole run needs under a thousand cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles > 5000) begin
            n_fail++;
            stop_test();
        end
    end

    initial begin
        int w;
        void'($urandom(14));
        repeat (10) @(posedge clk_sys);
        @(negedge clk_sys);
        reset = 1'h0;
        drive(1'h1, mk(5'h14, 5'h0, 2'h0, 1'h1, 3'h0), 2'h1, 32'h200, 32'h1003, 32'h5, 32'h0);
        // Every option in every mode, counts around the zero boundary
        for (int m = 0; m < 4; m++) begin
            for (int o = 0; o < 32; o++) begin
                for (int k = 0; k < 4; k++) begin
                    drive(1'h1, mk(o[4:0], 5'($urandom), 2'($urandom), 1'($urandom),
                                   3'($urandom)), m[1:0], $urandom, $urandom,
                          (k == 0) ? 32'h1 : (k == 1) ? 32'h2 : (k == 2) ? 32'h0 : $urandom,
                          $urandom);
                end
            end
        end
        // Mixed traffic with idle cycles and foreign words
        repeat (300) begin
            w = mk(5'($urandom), 5'($urandom), 2'($urandom), 1'($urandom), 3'($urandom));
            if ($urandom % 8 == 0) w = $urandom;
            if ($urandom % 8 == 1) w[10:1] = 10'($urandom);
            drive(1'($urandom % 8 != 0), w, 2'($urandom % 3), $urandom, $urandom,
                  32'($urandom % 3), $urandom);
        end
        drive(1'h0, 32'h0, 2'h0, 32'h0, 32'h0, 32'h0, 32'h0);
        repeat (3) @(posedge clk_sys);
        #3;
        stop_test();
    end

endmodule
